// >>> dsc_pkg.sv
// Package of register offsets, field positions and reset values for the debug system control block.
package dsc_pkg;

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [7:0] OFS_SYS_CTRL   = 8'h0a;
   localparam logic [7:0] OFS_SYS_STATUS = 8'h0b;
   localparam logic [7:0] OFS_SCAN_STAT  = 8'h0c;
   localparam logic [7:0] OFS_RST_REQ    = 8'h08;

   // ==========================================================================
   // Field positions
   // ==========================================================================
   localparam int BIT_CLK_REQ     = 0;
   localparam int BIT_UROW_DONE   = 1;
   localparam int BIT_LOCKED      = 0;
   localparam int BIT_BOOT_DONE   = 1;
   localparam int BIT_UROW_READY  = 2;
   localparam int BIT_NVM_READY   = 3;
   localparam int BIT_SLEEPING    = 4;
   localparam int BIT_RST_ACTIVE  = 5;
   localparam int BIT_ERASE_FAIL  = 6;
   localparam int BIT_BOOT_ERASE  = 7;

   // ==========================================================================
   // Values
   // ==========================================================================
   localparam logic [7:0] RST_SYS_CTRL   = 8'h00;
   localparam logic [7:0] RST_SYS_STATUS = 8'h01;
   localparam logic [7:0] RST_SCAN_STAT  = 8'h00;
   localparam logic [7:0] RST_REQ_VALUE  = 8'h59;
   localparam logic [7:0] RST_REQ_RUN    = 8'h00;
   localparam logic [2:0] SCAN_OFF       = 3'h0;
   localparam logic [2:0] SCAN_BUSY      = 3'h1;
   localparam logic [2:0] SCAN_PASS      = 3'h2;
   localparam logic [2:0] SCAN_FAIL      = 3'h4;
   localparam int         SYNC_STAGES    = 2;

endpackage

// >>> dsc_sync.sv
// Two-flop level synchroniser, one per bit, for flags that come from the system domain.
module dsc_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             i_clk,
   input  wire logic             i_rst,
   input  wire logic [WIDTH-1:0] i_async,
   output logic      [WIDTH-1:0] o_sync
);
   // The chain is fixed at two flops; another stage count would need new logic here.
   if (WIDTH < 1 || dsc_pkg::SYNC_STAGES != 2)
   begin : g_bad_config
      $error("dsc_sync: WIDTH must be at least one and SYNC_STAGES must be two.");
   end

   // ==========================================================================
   // Synchroniser chain
   // ==========================================================================
   // The first stage feeds only the second stage.
   logic [WIDTH-1:0] meta;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         meta   <= '0;
         o_sync <= '0;
      end
      else
      begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // dsc_sync

// >>> dsc_scan_status.sv
// Scan-check status encoder, mapping scan engine levels onto the one-hot status code.
module dsc_scan_status (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_enabled,
   input  wire logic       i_busy,
   input  wire logic       i_pass,
   output logic      [2:0] o_status
);
   // ==========================================================================
   // Encoding
   // ==========================================================================
   logic [2:0] next_status;

   // Only the four one-hot codes can ever be produced; reserved codes never appear.
   always_comb
   begin
      if (!i_enabled)
         next_status = dsc_pkg::SCAN_OFF;
      else if (i_busy)
         next_status = dsc_pkg::SCAN_BUSY;
      else if (i_pass)
         next_status = dsc_pkg::SCAN_PASS;
      else
         next_status = dsc_pkg::SCAN_FAIL;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_status <= dsc_pkg::RST_SCAN_STAT[2:0];
      else
         o_status <= next_status;
   end
endmodule // dsc_scan_status

// >>> dsc_debug_sys.sv
// Debug system control and status registers: clock request, user-row handshake, reset request and status.

// ==========================================================================
// Module
// ==========================================================================
// Functional notes
// - Writing done one starts user-row flash programming.
// - Done bit writable only after key_a decoded.
// - Clock request bit drives system clock request.
// - Interface enable sets clock request automatically.
// - Boot/erase flag is erase-failed OR boot-complete.
// - Erase-failed set on failure, cleared by reset.
// - Reset-active flag follows system reset state.
// - Status read clears reset-active flag.
// - Sleeping flag shows idle or deeper sleep.
// - NVM-ready flag shows programming permitted.
// - User-row-ready flag shows user-row programming permitted.
// - Boot-complete flag; access refused until set.
// - Lock flag follows lock; status resets 0x01.
// - Scan status one-hot: off, busy, pass, fail.
// - Signature write asserts system reset; zero releases.
module dsc_debug_sys (
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_wr,
   input  wire logic       i_rd,
   input  wire logic [7:0] i_addr,
   input  wire logic [7:0] i_wdata,
   input  wire logic       i_iface_enable,
   input  wire logic       i_userrow_key_ok,
   input  wire logic       i_sys_in_reset,
   input  wire logic       i_sys_sleeping,
   input  wire logic       i_boot_complete,
   input  wire logic       i_erase_fail_evt,
   input  wire logic       i_nvm_locked,
   input  wire logic       i_nvm_program_ready,
   input  wire logic       i_userrow_program_ready,
   input  wire logic       i_scan_enabled,
   input  wire logic       i_scan_busy,
   input  wire logic       i_scan_pass,
   output logic      [7:0] o_rdata,
   output logic            o_sysclk_request,
   output logic            o_userrow_start,
   output logic            o_sys_reset_req,
   output logic            o_access_allowed
);
   // ==========================================================================
   // Synchronised system flags
   // ==========================================================================
   localparam int NSYNC = 7;
   logic [NSYNC-1:0] sys_raw;
   logic [NSYNC-1:0] sys_sync;
   logic [2:0]       scan_status;

   assign sys_raw = {i_sys_in_reset, i_sys_sleeping, i_boot_complete, i_erase_fail_evt,
                     i_nvm_locked, i_nvm_program_ready, i_userrow_program_ready};

   dsc_sync #(
      .WIDTH (NSYNC)
   ) u_sync (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_async (sys_raw),
      .o_sync  (sys_sync)
   );

   dsc_scan_status u_scan (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_enabled (i_scan_enabled),
      .i_busy    (i_scan_busy),
      .i_pass    (i_scan_pass),
      .o_status  (scan_status)
   );

   logic s_in_reset;
   logic s_sleeping;
   logic s_boot;
   logic s_erase_evt;
   logic s_locked;
   logic s_nvm_ready;
   logic s_urow_ready;

   assign {s_in_reset, s_sleeping, s_boot, s_erase_evt, s_locked, s_nvm_ready, s_urow_ready} = sys_sync;

   // ==========================================================================
   // Decode
   // ==========================================================================
   logic wr_ctrl;
   logic wr_reset_request_value;
   logic rd_status;
   logic en_d;
   logic sys_rst_held;

   assign wr_ctrl   = i_wr && (i_addr == dsc_pkg::OFS_SYS_CTRL);
   assign wr_reset_request_value = i_wr && (i_addr == dsc_pkg::OFS_RST_REQ);
   assign rd_status = i_rd && (i_addr == dsc_pkg::OFS_SYS_STATUS);

   // ==========================================================================
   // Control register
   // ==========================================================================
   // The enable edge wins over a simultaneous write of zero so the debugger is never locked out.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         en_d             <= 1'b0;
         o_sysclk_request <= dsc_pkg::RST_SYS_CTRL[dsc_pkg::BIT_CLK_REQ];
      end
      else
      begin
         en_d <= i_iface_enable;
         if (i_iface_enable && !en_d)
            o_sysclk_request <= 1'b1;
         else if (wr_ctrl)
            o_sysclk_request <= i_wdata[dsc_pkg::BIT_CLK_REQ];
      end
   end

   // The done bit acts as a one-cycle start pulse; it reads back as zero.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_userrow_start <= 1'b0;
      else
         o_userrow_start <= wr_ctrl && i_wdata[dsc_pkg::BIT_UROW_DONE] && i_userrow_key_ok;
   end

   // ==========================================================================
   // Reset request
   // ==========================================================================
   // Other values are reserved; they leave the held reset unchanged.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sys_rst_held <= 1'b0;
      else if (wr_reset_request_value && i_wdata == dsc_pkg::RST_REQ_VALUE)
         sys_rst_held <= 1'b1;
      else if (wr_reset_request_value && i_wdata == dsc_pkg::RST_REQ_RUN)
         sys_rst_held <= 1'b0;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_sys_reset_req <= 1'b0;
      else
         o_sys_reset_req <= sys_rst_held;
   end

   // ==========================================================================
   // Status flags
   // ==========================================================================
   logic erase_failed;
   logic rst_active;
   logic in_reset_any;

   assign in_reset_any = s_in_reset || sys_rst_held;

   // Reset clears the failure; a new failure in the same cycle is dropped since the domain is in reset.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         erase_failed <= 1'b0;
      else if (in_reset_any)
         erase_failed <= 1'b0;
      else if (s_erase_evt)
         erase_failed <= 1'b1;
   end

   // Set while reset is present wins over the clear by read, so an ongoing reset is never hidden.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         rst_active <= 1'b0;
      else if (in_reset_any)
         rst_active <= 1'b1;
      else if (rd_status)
         rst_active <= 1'b0;
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_access_allowed <= 1'b0;
      else
         o_access_allowed <= s_boot;
   end

   // ==========================================================================
   // Read data
   // ==========================================================================
   logic [7:0] status_word;
   logic [7:0] next_rdata;

   always_comb
   begin
      status_word                          = 8'h00;
      status_word[dsc_pkg::BIT_BOOT_ERASE] = erase_failed || s_boot;
      status_word[dsc_pkg::BIT_ERASE_FAIL] = erase_failed;
      status_word[dsc_pkg::BIT_RST_ACTIVE] = rst_active;
      status_word[dsc_pkg::BIT_SLEEPING]   = s_sleeping;
      status_word[dsc_pkg::BIT_NVM_READY]  = s_nvm_ready;
      status_word[dsc_pkg::BIT_UROW_READY] = s_urow_ready;
      status_word[dsc_pkg::BIT_BOOT_DONE]  = s_boot;
      status_word[dsc_pkg::BIT_LOCKED]     = s_locked;
   end

   always_comb
   begin
      next_rdata = 8'h00;
      if (i_rd)
      begin
         case (i_addr)
            dsc_pkg::OFS_SYS_CTRL:   next_rdata = {7'h00, o_sysclk_request};
            dsc_pkg::OFS_SYS_STATUS: next_rdata = status_word;
            dsc_pkg::OFS_SCAN_STAT:  next_rdata = {5'h00, scan_status};
            dsc_pkg::OFS_RST_REQ:    next_rdata = sys_rst_held ? dsc_pkg::RST_REQ_VALUE : dsc_pkg::RST_REQ_RUN;
            default:                 next_rdata = 8'h00;
         endcase
      end
   end

   // Status resets to lock set; the reset-time read is the fixed RST_SYS_STATUS value, not the lock flag, before synchronisers settle.
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_rdata <= dsc_pkg::RST_SYS_STATUS;
      else
         o_rdata <= next_rdata;
   end

   // ==========================================================================
   // Checks
   // ==========================================================================
   a_clk_enable: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_iface_enable && !en_d) |=> o_sysclk_request)
      else $error("Clock request not set on interface enable.");
   a_clk_write: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ctrl && !(i_iface_enable && !en_d)) |=> (o_sysclk_request == $past(i_wdata[0])))
      else $error("Clock request does not follow write.");
   a_urow_start: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_ctrl && i_wdata[1] && i_userrow_key_ok) |=> o_userrow_start)
      else $error("User-row start missing.");
   a_urow_key: assert property (@(posedge i_clk) disable iff (i_rst)
      !i_userrow_key_ok |=> !o_userrow_start)
      else $error("User-row start without key.");
   a_rst_req: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_reset_request_value && i_wdata == 8'h59) |=> ##1 o_sys_reset_req)
      else $error("Reset request not asserted.");
   a_rst_release: assert property (@(posedge i_clk) disable iff (i_rst)
      (wr_reset_request_value && i_wdata == 8'h00) |=> ##1 !o_sys_reset_req)
      else $error("Reset request not released.");
   a_rst_active: assert property (@(posedge i_clk) disable iff (i_rst)
      in_reset_any |=> rst_active)
      else $error("Reset-active flag not set.");
   a_read_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      (rd_status && !in_reset_any) |=> !rst_active)
      else $error("Reset-active flag not cleared by read.");
   a_erase_clear: assert property (@(posedge i_clk) disable iff (i_rst)
      in_reset_any |=> !erase_failed)
      else $error("Erase-failed not cleared by reset.");
   a_boot_erase: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_status |=> (o_rdata[7] == (o_rdata[6] || o_rdata[1])))
      else $error("Boot/erase flag inconsistent.");
   a_scan_onehot: assert property (@(posedge i_clk) disable iff (i_rst)
      $onehot0(scan_status))
      else $error("Scan status not one-hot.");
   a_unused_zero: assert property (@(posedge i_clk) disable iff (i_rst)
      (i_rd && i_addr == dsc_pkg::OFS_SYS_CTRL) |=> (o_rdata[7:1] == 7'h00))
      else $error("Unused control bits not zero.");
   a_sleep_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_status |=> (o_rdata[dsc_pkg::BIT_SLEEPING] == $past(i_sys_sleeping, 3)))
      else $error("Sleeping flag does not follow system sleep.");
   a_nvm_ready: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_status |=> (o_rdata[dsc_pkg::BIT_NVM_READY] == $past(i_nvm_program_ready, 3)))
      else $error("NVM-ready flag does not follow its source.");
   a_urow_ready: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_status |=> (o_rdata[dsc_pkg::BIT_UROW_READY] == $past(i_userrow_program_ready, 3)))
      else $error("User-row-ready flag does not follow its source.");
   a_lock_flag: assert property (@(posedge i_clk) disable iff (i_rst)
      rd_status |=> (o_rdata[dsc_pkg::BIT_LOCKED] == $past(i_nvm_locked, 3)))
      else $error("Lock flag does not follow lock state.");
   a_access_boot: assert property (@(posedge i_clk) disable iff (i_rst)
      o_access_allowed == $past(i_boot_complete, 3))
      else $error("Access allowed does not follow boot complete.");
   a_sync_latency: assert property (@(posedge i_clk) disable iff (i_rst)
      s_in_reset == $past(i_sys_in_reset, 2))
      else $error("System reset flag not passed through two flops.");

   c_urow: cover property (@(posedge i_clk) disable iff (i_rst) o_userrow_start);
   c_reset: cover property (@(posedge i_clk) disable iff (i_rst) $rose(o_sys_reset_req));
   c_clear: cover property (@(posedge i_clk) disable iff (i_rst) $fell(rst_active));
   c_scanfail: cover property (@(posedge i_clk) disable iff (i_rst) scan_status == 3'h4);
   c_enable: cover property (@(posedge i_clk) disable iff (i_rst) i_iface_enable && !en_d);
endmodule // dsc_debug_sys

// >>> dsc_debugger_model.sv
// Debugger model issuing single-byte register reads and writes to the block.
module dsc_debugger_model (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_addr,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 8'h00;
   end

   // ==========================================================================
   // Bus cycles
   // ==========================================================================
   // Idle address and data are inverted so a stale value never looks valid.
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clk);
      o_wr <= 1'b1;
      o_addr <= addr;
      o_wdata <= data;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~addr;
      o_wdata <= ~data;
      #1;
   endtask

   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      @(posedge i_clk);
      o_rd <= 1'b1;
      o_addr <= addr;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~addr;
      #1;
      data = i_rdata;
   endtask
endmodule // dsc_debugger_model

// >>> test_debug_system_ctrl_status.sv
// Self-checking testbench for the debug system control and status block.
module test_debug_system_ctrl_status;
   timeunit 1ns;
   timeprecision 100ps;

   logic       i_clk, i_rst, i_wr, i_rd, i_iface_enable, i_userrow_key_ok;
   logic       i_sys_in_reset, i_sys_sleeping, i_boot_complete, i_erase_fail_evt;
   logic       i_nvm_locked, i_nvm_program_ready, i_userrow_program_ready;
   logic       i_scan_enabled, i_scan_busy, i_scan_pass;
   logic [7:0] i_addr, i_wdata, o_rdata, rd_val;
   logic       o_sysclk_request, o_userrow_start, o_sys_reset_req, o_access_allowed;
   logic       exp_erase, rst_seen;
   logic [6:0] v;
   int         miscompares = 0;
   int         total_checks = 0;
   int         cycles = 0;

   dsc_debug_sys i_dut (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_iface_enable(i_iface_enable), .i_userrow_key_ok(i_userrow_key_ok),
      .i_sys_in_reset(i_sys_in_reset), .i_sys_sleeping(i_sys_sleeping), .i_boot_complete(i_boot_complete),
      .i_erase_fail_evt(i_erase_fail_evt), .i_nvm_locked(i_nvm_locked),
      .i_nvm_program_ready(i_nvm_program_ready), .i_userrow_program_ready(i_userrow_program_ready),
      .i_scan_enabled(i_scan_enabled), .i_scan_busy(i_scan_busy), .i_scan_pass(i_scan_pass),
      .o_rdata(o_rdata), .o_sysclk_request(o_sysclk_request), .o_userrow_start(o_userrow_start),
      .o_sys_reset_req(o_sys_reset_req), .o_access_allowed(o_access_allowed));

   dsc_debugger_model i_dbg (.i_clk(i_clk), .i_rdata(o_rdata), .o_wr(i_wr), .o_rd(i_rd),
      .o_addr(i_addr), .o_wdata(i_wdata));

   initial
   begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end

   // ==========================================================================
   // Checking
   // ==========================================================================
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   always @(posedge i_clk)
   begin
      cycles++;
      if (cycles > 3000)
      begin
         miscompares++;
         end_sim();
      end
   end

   // System flags pass two sync flops, so four cycles of hold is ample.
   task automatic set_sys(input logic [6:0] f);
      @(posedge i_clk);
      {i_sys_in_reset, i_sys_sleeping, i_boot_complete, i_nvm_locked} <= f[6:3];
      {i_nvm_program_ready, i_userrow_program_ready, i_erase_fail_evt} <= f[2:0];
      repeat (4) @(posedge i_clk);
      #1;
      rst_seen = rst_seen | f[6];
      exp_erase = exp_erase | f[0];
   endtask

   task automatic chk_status();
      logic [7:0] e;
      e = {exp_erase | i_boot_complete, exp_erase, rst_seen, i_sys_sleeping, i_nvm_program_ready,
           i_userrow_program_ready, i_boot_complete, i_nvm_locked};
      i_dbg.rd(dsc_pkg::OFS_SYS_STATUS, rd_val);
      chk("status", e, rd_val);
      rst_seen = i_sys_in_reset;
   endtask

   // ==========================================================================
   // Tests
   // ==========================================================================
   initial
   begin
      {i_iface_enable, i_userrow_key_ok, i_scan_enabled, i_scan_busy, i_scan_pass} = 5'h00;
      {i_sys_in_reset, i_sys_sleeping, i_boot_complete, i_erase_fail_evt} = 4'h0;
      {i_nvm_locked, i_nvm_program_ready, i_userrow_program_ready} = 3'h0;
      exp_erase = 1'b0;
      rst_seen = 1'b0;
      void'($urandom(32'h4dd3));
      i_rst = 1'b1;
      repeat (6) @(posedge i_clk);
      chk("rdata in reset", dsc_pkg::RST_SYS_STATUS, o_rdata);
      i_rst <= 1'b0;
      $display("test reset done");

      i_dbg.wr(dsc_pkg::OFS_SYS_CTRL, 8'h02);
      chk("start no key", 8'h00, {7'h00, o_userrow_start});
      i_dbg.wr(dsc_pkg::OFS_SYS_CTRL, 8'h01);
      chk("sysclk_request set", 8'h01, {7'h00, o_sysclk_request});
      i_dbg.wr(dsc_pkg::OFS_SYS_CTRL, 8'h00);
      chk("sysclk_request clear", 8'h00, {7'h00, o_sysclk_request});
      @(posedge i_clk);
      i_userrow_key_ok <= 1'b1;
      i_dbg.wr(dsc_pkg::OFS_SYS_CTRL, 8'hff);
      chk("start pulse", 8'h01, {7'h00, o_userrow_start});
      @(posedge i_clk);
      #1;
      chk("start end", 8'h00, {7'h00, o_userrow_start});
      i_dbg.wr(8'h07, 8'h20);
      i_dbg.rd(dsc_pkg::OFS_SYS_CTRL, rd_val);
      chk("ctrl read", 8'h01, rd_val);
      i_dbg.wr(dsc_pkg::OFS_SYS_CTRL, 8'h00);
      @(posedge i_clk);
      i_iface_enable <= 1'b1;
      repeat (4) @(posedge i_clk);
      #1;
      chk("sysclk_request enable", 8'h01, {7'h00, o_sysclk_request});
      i_dbg.wr(8'h0e, 8'hff);
      i_dbg.rd(8'h0e, rd_val);
      chk("unmapped", 8'h00, rd_val);
      $display("test control done");

      for (int k = 0; k < 12; k++)
      begin
         v = 7'($urandom()) & 7'h7e;
         set_sys(v);
         chk("access", {7'h00, i_boot_complete}, {7'h00, o_access_allowed});
         chk_status();
         chk_status();
      end
      $display("test status done");

      set_sys(7'h11);
      set_sys(7'h10);
      chk_status();
      i_dbg.wr(dsc_pkg::OFS_RST_REQ, 8'h59);
      @(posedge i_clk);
      #1;
      chk("reset_request_value on", 8'h01, {7'h00, o_sys_reset_req});
      i_dbg.wr(dsc_pkg::OFS_RST_REQ, 8'h33);
      i_dbg.rd(dsc_pkg::OFS_RST_REQ, rd_val);
      chk("reset_request_value read", dsc_pkg::RST_REQ_VALUE, rd_val);
      exp_erase = 1'b0;
      set_sys(7'h50);
      chk_status();
      i_dbg.wr(dsc_pkg::OFS_RST_REQ, 8'h00);
      @(posedge i_clk);
      #1;
      chk("reset_request_value off", 8'h00, {7'h00, o_sys_reset_req});
      set_sys(7'h10);
      chk_status();
      chk_status();
      $display("test erase and reset done");

      for (int k = 0; k < 8; k++)
      begin
         @(posedge i_clk);
         {i_scan_enabled, i_scan_busy, i_scan_pass} <= 3'(k);
         repeat (3) @(posedge i_clk);
         i_dbg.rd(dsc_pkg::OFS_SCAN_STAT, rd_val);
         chk("scan", (k < 4) ? 8'h00 : (k >= 6) ? 8'h01 : (k == 5) ? 8'h02 : 8'h04, rd_val);
      end
      $display("test scan done");
      end_sim();
   end
endmodule // test_debug_system_ctrl_status
